// *** verilog/pswl_top.sv ***
// Purpose: panel stop latch, panel loss trip and parameter write lock of a drive
// Assumes: key, mode, run and trip inputs come from logic on core_clk
// Notes:   rst_n doubles as the power-supply reset
`timescale 1ns/1ps
module pswl_top #(
	parameter int LOSS_CYCLES = pswl_pkg::PANEL_LOSS_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        handheld_panel_present,
	input  wire logic        clear_input,
	input  wire logic        forward_start_input,
	input  wire logic        reverse_start_input,
	input  wire logic        comm_reset,
	input  wire logic        stop_key_builtin,
	input  wire logic        stop_key_handheld,
	input  wire logic        mode_key_builtin,
	input  wire logic        mode_key_handheld,
	input  wire logic [1:0]  op_mode,
	input  wire logic        rs485_via_panel_port,
	input  wire logic        panel_jog_active,
	input  wire logic        motor_running,
	input  wire logic        drive_tripped,
	input  wire logic        chk_valid,
	input  wire logic [9:0]  chk_num,
	input  wire logic [1:0]  chk_kind,
	input  wire logic        chk_always_writable,
	output logic             chk_done,
	output logic             chk_grant,
	output logic             panel_stop_state,
	output logic             decel_stop_cmd,
	output logic             stop_coast_sel,
	output logic             run_permit,
	output logic             fault_out,
	output logic             panel_loss_fault,
	output logic             reset_accept,
	output logic             handheld_is_source
);

	localparam int LW = $clog2(LOSS_CYCLES + 1);
	localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYCLES - 1);

	// pin index within the synchroniser
	localparam int P_PRES = 3;
	localparam int P_CLR  = 2;
	localparam int P_FWD  = 1;
	localparam int P_REV  = 0;

	typedef enum logic [1:0] {
		STOP_IDLE,
		STOP_LOCAL,
		STOP_PANEL
	} pswl_stop_t;

	typedef struct packed {
		logic [3:0]  s1;
		logic [3:0]  s2;
		logic [3:0]  s3;
		logic [3:0]  pins;
		logic [4:0]  srs;
		logic [1:0]  wp;
		logic        coast_sel;
		logic        src_def;
		logic        disp_ext;
		pswl_stop_t  stop;
		logic        issuer_hh;
		logic        jog_stop;
		logic        hh_seen;
		logic        loss_fault;
		logic [LW-1:0] loss_cnt;
		logic        clr_prev;
		logic        reset_pulse;
		logic [31:0] rdata;
		logic        chk_done;
		logic        chk_grant;
	} pswl_state_t;

	pswl_state_t state_reg;
	pswl_state_t state_next;

	logic hh_present;
	logic starts_on;
	logic hi_group;
	logic trip_setting;
	logic detect_en;
	logic tripped;
	logic reset_ok;
	logic reset_take;
	logic panel_mode;
	logic key_hh;
	logic key_src;
	logic key_off;
	logic ps_set;
	logic ps_issuer_hh;
	logic local_set;
	logic ps_reset;
	logic in_inhibit_exc;
	logic in_run_locked;
	logic grant_now;
	logic [4:0] wr_srs;
	logic [1:0] wr_wp;

	assign hh_present   = state_reg.pins[P_PRES];
	assign starts_on    = state_reg.pins[P_FWD] | state_reg.pins[P_REV];
	assign panel_mode   = (op_mode == pswl_pkg::MODE_PANEL);
	assign hi_group     = (state_reg.srs >= pswl_pkg::SRS_HI_FIRST);
	assign trip_setting = (state_reg.srs == 5'h02) | (state_reg.srs == 5'h03)
		| (state_reg.srs == 5'h10) | (state_reg.srs == 5'h11);
	assign detect_en    = trip_setting & ~rs485_via_panel_port;
	assign tripped      = drive_tripped | state_reg.loss_fault;
	assign reset_ok     = ~state_reg.srs[0] | tripped;
	assign reset_take   = ((state_reg.pins[P_CLR] & ~state_reg.clr_prev) | comm_reset)
		& reset_ok;

	// command source among the two panels
	assign handheld_is_source = state_reg.src_def & hh_present;
	assign key_hh  = stop_key_handheld & hh_present;
	assign key_src = handheld_is_source ? key_hh : stop_key_builtin;
	assign key_off = handheld_is_source ? stop_key_builtin : key_hh;

	// panel stop request and the unit that made it
	always_comb begin
		ps_set       = 1'b0;
		ps_issuer_hh = 1'b0;
		local_set    = 1'b0;
		if (hi_group) begin
			if (!panel_mode) begin
				ps_set       = stop_key_builtin | key_hh;
				ps_issuer_hh = key_hh;
			end else if (key_off) begin
				ps_set       = 1'b1;
				ps_issuer_hh = ~handheld_is_source;
			end else if (rs485_via_panel_port & stop_key_builtin) begin
				ps_set       = 1'b1;
				ps_issuer_hh = 1'b0;
			end else begin
				local_set    = key_src;
			end
		end else begin
			local_set = panel_mode & (stop_key_builtin | key_hh);
		end
	end

	// stop reset only from the issuing unit, at standstill with starts released
	assign ps_reset = (state_reg.issuer_hh ? mode_key_handheld : mode_key_builtin)
		& ~motor_running & ~starts_on;

	// parameter list membership
	always_comb begin
		in_inhibit_exc = 1'b0;
		in_run_locked  = 1'b0;
		for (int i = 0; i < pswl_pkg::INH_N; i++) begin
			if (chk_num == pswl_pkg::INHIBIT_EXC[i]) begin
				in_inhibit_exc = 1'b1;
			end
		end
		for (int i = 0; i < pswl_pkg::RUN_N; i++) begin
			if (chk_num == pswl_pkg::RUN_LOCKED[i]) begin
				in_run_locked = 1'b1;
			end
		end
	end

	// write permission of one parameter access
	always_comb begin
		grant_now = 1'b0;
		if (chk_kind == pswl_pkg::KIND_READ) begin
			grant_now = 1'b1;
		end else begin
			case (state_reg.wp)
				pswl_pkg::WP_STOP_ONLY: begin
					if (chk_kind != pswl_pkg::KIND_WRITE) begin
						grant_now = panel_mode & ~motor_running;
					end else if (chk_num == pswl_pkg::PN_CARRIER
						|| chk_num == pswl_pkg::PN_SOFT_MOD) begin
						grant_now = panel_mode;
					end else begin
						grant_now = chk_always_writable
							| (panel_mode & ~motor_running);
					end
				end
				pswl_pkg::WP_INHIBIT: begin
					grant_now = (chk_kind == pswl_pkg::KIND_WRITE) & in_inhibit_exc;
				end
				pswl_pkg::WP_ALWAYS: begin
					if (chk_kind == pswl_pkg::KIND_WRITE) begin
						grant_now = ~(motor_running & in_run_locked);
					end else begin
						grant_now = ~motor_running;
					end
				end
				default: begin
					grant_now = 1'b0;
				end
			endcase
			if (chk_kind == pswl_pkg::KIND_WRITE && chk_num == pswl_pkg::PN_WP
				&& !state_reg.disp_ext) begin
				grant_now = 1'b0;
			end
		end
	end

	// register write fields, kept when the value is out of range
	assign wr_srs = reg_wdata[pswl_pkg::CFG_SRS_LSB +: 5];
	assign wr_wp  = reg_wdata[pswl_pkg::CFG_WP_LSB +: 2];

	always_comb begin
		state_next = state_reg;

		// pin synchronisers: a change counts once stages two and three agree
		state_next.s1 = {handheld_panel_present, clear_input,
			forward_start_input, reverse_start_input};
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		for (int i = 0; i < 4; i++) begin
			if (state_reg.s2[i] == state_reg.s3[i]) begin
				state_next.pins[i] = state_reg.s3[i];
			end
		end
		state_next.clr_prev    = state_reg.pins[P_CLR];
		state_next.reset_pulse = reset_take;

		// configuration writes
		if (reg_wr && reg_addr == pswl_pkg::ADDR_CFG) begin
			if (wr_srs <= pswl_pkg::SRS_LO_LAST
				|| (wr_srs >= pswl_pkg::SRS_HI_FIRST && wr_srs <= pswl_pkg::SRS_HI_LAST)) begin
				state_next.srs = wr_srs;
			end
			if (state_reg.disp_ext && wr_wp != 2'h3) begin
				state_next.wp = wr_wp;
			end
			state_next.coast_sel = reg_wdata[pswl_pkg::CFG_COAST];
			state_next.src_def   = reg_wdata[pswl_pkg::CFG_SRC_DEF];
			state_next.disp_ext  = reg_wdata[pswl_pkg::CFG_DISP_EXT];
		end

		// register reads: data stand only in the cycle after the strobe
		state_next.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				pswl_pkg::ADDR_CFG: begin
					state_next.rdata[pswl_pkg::CFG_SRS_LSB +: 5] = state_reg.srs;
					state_next.rdata[pswl_pkg::CFG_WP_LSB +: 2]  = state_reg.wp;
					state_next.rdata[pswl_pkg::CFG_COAST]        = state_reg.coast_sel;
					state_next.rdata[pswl_pkg::CFG_SRC_DEF]      = state_reg.src_def;
					state_next.rdata[pswl_pkg::CFG_DISP_EXT]     = state_reg.disp_ext;
				end
				pswl_pkg::ADDR_STATUS: begin
					state_next.rdata[pswl_pkg::ST_PANEL_STOP] = state_reg.stop == STOP_PANEL;
					state_next.rdata[pswl_pkg::ST_LOSS_FAULT] = state_reg.loss_fault;
					state_next.rdata[pswl_pkg::ST_JOG_STOP]   = state_reg.jog_stop;
					state_next.rdata[pswl_pkg::ST_LOCAL_STOP] = state_reg.stop == STOP_LOCAL;
					state_next.rdata[pswl_pkg::ST_ISSUER_HH]  = state_reg.issuer_hh;
					state_next.rdata[pswl_pkg::ST_HH_PRESENT] = hh_present;
					state_next.rdata[pswl_pkg::ST_SRC_HH]     = handheld_is_source;
					state_next.rdata[pswl_pkg::ST_HH_SEEN]    = state_reg.hh_seen;
				end
				default: begin
					state_next.rdata = 32'h0000_0000;
				end
			endcase
		end

		// stop latch; a new stop in the reset cycle keeps the latch set
		case (state_reg.stop)
			STOP_IDLE: begin
				if (ps_set) begin
					state_next.stop      = STOP_PANEL;
					state_next.issuer_hh = ps_issuer_hh;
				end else if (local_set) begin
					state_next.stop = STOP_LOCAL;
				end
			end
			STOP_LOCAL: begin
				if (ps_set) begin
					state_next.stop      = STOP_PANEL;
					state_next.issuer_hh = ps_issuer_hh;
				end else if (!motor_running) begin
					state_next.stop = STOP_IDLE;
				end
			end
			STOP_PANEL: begin
				if (ps_set) begin
					state_next.issuer_hh = ps_issuer_hh;
				end else if (ps_reset || reset_take) begin
					state_next.stop = STOP_IDLE;
				end
			end
			default: begin
				state_next.stop = STOP_IDLE;
			end
		endcase

		// panel removed during panel jog with operation continued
		if (!trip_setting && panel_jog_active && !hh_present && state_reg.hh_seen) begin
			state_next.jog_stop = 1'b1;
		end else if (!motor_running) begin
			state_next.jog_stop = 1'b0;
		end

		// panel loss detection, only after the panel has been seen
		if (hh_present) begin
			state_next.hh_seen = 1'b1;
		end
		if (detect_en && state_reg.hh_seen && !hh_present) begin
			if (state_reg.loss_cnt == LOSS_LAST) begin
				state_next.loss_fault = 1'b1;
			end else begin
				state_next.loss_cnt = state_reg.loss_cnt + LW'(1);
			end
		end else begin
			state_next.loss_cnt = '0;
		end
		if (reset_take && !(state_next.loss_fault && !state_reg.loss_fault)) begin
			state_next.loss_fault = 1'b0;
			state_next.loss_cnt   = '0;
		end

		// parameter access check, answered one cycle later
		state_next.chk_done  = chk_valid;
		state_next.chk_grant = chk_valid & grant_now;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg             <= '0;
			state_reg.srs         <= pswl_pkg::SRS_RESET;
			state_reg.wp          <= pswl_pkg::WP_RESET;
			state_reg.coast_sel   <= pswl_pkg::COAST_RESET;
			state_reg.src_def     <= pswl_pkg::SRC_DEF_RESET;
			state_reg.disp_ext    <= pswl_pkg::DISP_EXT_RESET;
			state_reg.stop        <= STOP_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata        = state_reg.rdata;
	assign chk_done         = state_reg.chk_done;
	assign chk_grant        = state_reg.chk_grant;
	assign panel_stop_state = state_reg.stop == STOP_PANEL;
	assign decel_stop_cmd   = (state_reg.stop != STOP_IDLE) | state_reg.jog_stop;
	assign stop_coast_sel   = state_reg.coast_sel & (state_reg.stop != STOP_PANEL);
	assign run_permit       = (state_reg.stop != STOP_PANEL) & ~state_reg.loss_fault
		& ~state_reg.jog_stop;
	assign fault_out        = state_reg.loss_fault;
	assign panel_loss_fault = state_reg.loss_fault;
	assign reset_accept     = state_reg.reset_pulse;

endmodule

// *** verilog/pswl_pkg.sv ***
// Purpose: shared constants for the panel stop and parameter write lock block
// Assumes: controller clock of 20 MHz
// Notes:   parameter numbers are the drive's own parameter numbers
package pswl_pkg;

	// timing
	localparam int CLK_HZ            = 20_000_000;
	localparam int PANEL_LOSS_MS     = 1000;
	localparam int PANEL_LOSS_CYCLES = PANEL_LOSS_MS * (CLK_HZ / 1000);

	// register port
	localparam int         ADDR_W      = 4;
	localparam logic [3:0] ADDR_CFG    = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	// configuration register fields
	localparam int CFG_SRS_LSB  = 0;
	localparam int CFG_WP_LSB   = 8;
	localparam int CFG_COAST    = 12;
	localparam int CFG_SRC_DEF  = 13;
	localparam int CFG_DISP_EXT = 14;

	// configuration reset values
	localparam logic [4:0] SRS_RESET      = 5'h0e;
	localparam logic [1:0] WP_RESET       = 2'h0;
	localparam logic       COAST_RESET    = 1'h0;
	localparam logic       SRC_DEF_RESET  = 1'h1;
	localparam logic       DISP_EXT_RESET = 1'h1;

	// status register fields
	localparam int ST_PANEL_STOP = 0;
	localparam int ST_LOSS_FAULT = 1;
	localparam int ST_JOG_STOP   = 2;
	localparam int ST_LOCAL_STOP = 3;
	localparam int ST_ISSUER_HH  = 4;
	localparam int ST_HH_PRESENT = 5;
	localparam int ST_SRC_HH     = 6;
	localparam int ST_HH_SEEN    = 7;

	// write protection modes
	localparam logic [1:0] WP_STOP_ONLY = 2'h0;
	localparam logic [1:0] WP_INHIBIT   = 2'h1;
	localparam logic [1:0] WP_ALWAYS    = 2'h2;

	// operating modes
	localparam logic [1:0] MODE_PANEL    = 2'h0;
	localparam logic [1:0] MODE_TERMINAL = 2'h1;
	localparam logic [1:0] MODE_NETWORK  = 2'h2;

	// access kinds of a parameter check
	localparam logic [1:0] KIND_READ      = 2'h0;
	localparam logic [1:0] KIND_WRITE     = 2'h1;
	localparam logic [1:0] KIND_CLEAR     = 2'h2;
	localparam logic [1:0] KIND_ALL_CLEAR = 2'h3;

	// stop/reset selection settings
	localparam logic [4:0] SRS_HI_FIRST = 5'h0e;
	localparam logic [4:0] SRS_HI_LAST  = 5'h11;
	localparam logic [4:0] SRS_LO_LAST  = 5'h03;

	// parameter numbers
	localparam int         PN_W        = 10;
	localparam logic [9:0] PN_CARRIER  = 10'h048;
	localparam logic [9:0] PN_SOFT_MOD = 10'h0f0;
	localparam logic [9:0] PN_WP       = 10'h04d;

	localparam int INH_N = 7;
	localparam logic [INH_N-1:0][9:0] INHIBIT_EXC = {
		10'h016, 10'h04b, 10'h04d, 10'h04f, 10'h0a0, 10'h128, 10'h129};

	localparam int RUN_N = 31;
	localparam logic [RUN_N-1:0][9:0] RUN_LOCKED = {
		10'h017, 10'h028, 10'h030, 10'h03c, 10'h042, 10'h047, 10'h04f, 10'h050,
		10'h052, 10'h053, 10'h054, 10'h05a, 10'h060, 10'h0b2, 10'h0b3, 10'h0b4,
		10'h0b5, 10'h0b6, 10'h0be, 10'h0c0, 10'h0ff, 10'h100, 10'h101, 10'h102,
		10'h105, 10'h12a, 10'h157, 10'h1c2, 10'h231, 10'h233, 10'h234};

endpackage

// *** sim/pswl_chk_assertions.sv ***
// Purpose: port level checks of the panel stop and write lock block
// Assumes: one clock domain, synchronous active low reset
// Notes:   bound into pswl_top at the foot of this file
`timescale 1ns/1ps
module pswl_chk_assertions (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        stop_key_builtin,
	input wire logic        stop_key_handheld,
	input wire logic        mode_key_builtin,
	input wire logic        mode_key_handheld,
	input wire logic        rs485_via_panel_port,
	input wire logic        chk_valid,
	input wire logic [1:0]  chk_kind,
	input wire logic        chk_done,
	input wire logic        chk_grant,
	input wire logic        panel_stop_state,
	input wire logic        stop_coast_sel,
	input wire logic        run_permit,
	input wire logic        fault_out,
	input wire logic        panel_loss_fault,
	input wire logic        reset_accept
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_chk_s;
		chk_valid && chk_kind == pswl_pkg::KIND_READ;
	endsequence
	sequence stop_key_s;
		stop_key_builtin || stop_key_handheld;
	endsequence
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside answer cycle");
	chk_done_a: assert property (chk_done == $past(chk_valid))
		else $error("check answer not one cycle after request");
	read_grant_a: assert property (rd_chk_s |=> chk_grant)
		else $error("parameter read refused");
	no_fault_a: assert property (panel_stop_state && !panel_loss_fault |-> !fault_out)
		else $error("fault output during panel stop");
	stop_block_a: assert property (panel_stop_state |-> !run_permit)
		else $error("restart permitted during panel stop");
	stop_decel_a: assert property (panel_stop_state |-> !stop_coast_sel)
		else $error("coasting selected during panel stop");
	stop_rise_a: assert property ($rose(panel_stop_state) |-> $past(stop_key_builtin || stop_key_handheld))
		else $error("panel stop set without stop key");
	stop_fall_a: assert property ($fell(panel_stop_state) |-> $past(mode_key_builtin || mode_key_handheld) || reset_accept)
		else $error("panel stop cleared without reset");
	loss_link_a: assert property ($rose(panel_loss_fault) |-> !$past(rs485_via_panel_port))
		else $error("loss fault with rs485 on panel port");
	accept_once_a: assert property (reset_accept |=> !reset_accept)
		else $error("reset accept longer than one cycle");
	cover property (stop_key_s ##1 panel_stop_state);
endmodule
bind pswl_top pswl_chk_assertions pswl_chk_assertions_i (.*);

// *** sim/pswl_panel_model.sv ***
// Purpose: operator panels and start terminals facing the block
// Assumes: key presses are one cycle pulses on core_clk
// Notes:   key index 0 builtin stop, 1 handheld stop, 2 builtin mode, 3 handheld mode
`timescale 1ns/1ps
module pswl_panel_model (
	input  wire logic core_clk,
	input  wire logic motor_running,
	output logic      stop_key_builtin,
	output logic      stop_key_handheld,
	output logic      mode_key_builtin,
	output logic      mode_key_handheld,
	output logic      handheld_panel_present,
	output logic      forward_start_input,
	output logic      reverse_start_input
);
	logic [3:0] keys = 4'h0;
	assign {mode_key_handheld, mode_key_builtin, stop_key_handheld, stop_key_builtin} = keys;
	initial begin
		handheld_panel_present = 1'h0;
		forward_start_input = 1'h0;
		reverse_start_input = 1'h0;
	end
	task automatic press(input int k);
		@(posedge core_clk);
		keys <= 4'h1 << k;
		@(posedge core_clk);
		keys <= 4'h0;
	endtask
	task automatic attach(input logic on);
		@(posedge core_clk);
		handheld_panel_present <= on;
	endtask
	task automatic start(input logic on, input logic dir);
		@(posedge core_clk);
		forward_start_input <= on & ~dir;
		reverse_start_input <= on & dir;
	endtask
	// wait standstill, drop starts, then mode key of the stopping unit
	task automatic stop_reset(input int unit);
		for (int i = 0; i < 100 && motor_running; i++) @(posedge core_clk);
		start(1'h0, 1'h0);
		repeat (6) @(posedge core_clk);
		press(2 + unit);
	endtask
endmodule

// *** sim/pswl_top_tb.sv ***
// Purpose: self-checking bench of the panel stop and write lock block
// Assumes: 20 MHz core_clk, loss time shortened to 20 cycles
// Notes:   pins pass a synchroniser, so pin changes get six cycles
`timescale 1ns/1ps
module pswl_top_tb;
	logic        core_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic        clear_input = 1'h0;
	logic        comm_reset = 1'h0;
	logic [1:0]  op_mode = 2'h0;
	logic        rs485 = 1'h0;
	logic        jog = 1'h0;
	logic        motor_running = 1'h0;
	logic        drive_tripped = 1'h0;
	logic        chk_valid = 1'h0;
	logic [9:0]  chk_num = 10'h000;
	logic [1:0]  chk_kind = 2'h0;
	logic        chk_aw = 1'h0;
	logic        chk_done, chk_grant, panel_stop_state, decel_stop_cmd, stop_coast_sel;
	logic        run_permit, fault_out, panel_loss_fault, hh_src, rst_acc;
	logic        sk_b, sk_h, mk_b, mk_h, hh_on, fwd, rev;
	int          mismatches = 0;
	int          total_checks = 0;
	logic [9:0]  exc [7] = '{10'h016, 10'h04b, 10'h04d, 10'h04f, 10'h0a0, 10'h128, 10'h129};
	logic [9:0]  lck [6] = '{10'h050, 10'h0b2, 10'h0b6, 10'h0be, 10'h0c0, 10'h234};
	always #25 core_clk = ~core_clk;
	pswl_top #(.LOSS_CYCLES(20)) pswl_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .handheld_panel_present(hh_on), .clear_input(clear_input),
		.forward_start_input(fwd), .reverse_start_input(rev), .comm_reset(comm_reset),
		.stop_key_builtin(sk_b), .stop_key_handheld(sk_h), .mode_key_builtin(mk_b),
		.mode_key_handheld(mk_h), .op_mode(op_mode), .rs485_via_panel_port(rs485),
		.panel_jog_active(jog), .motor_running(motor_running), .drive_tripped(drive_tripped),
		.chk_valid(chk_valid), .chk_num(chk_num), .chk_kind(chk_kind),
		.chk_always_writable(chk_aw), .chk_done(chk_done), .chk_grant(chk_grant),
		.panel_stop_state(panel_stop_state), .decel_stop_cmd(decel_stop_cmd),
		.stop_coast_sel(stop_coast_sel), .run_permit(run_permit), .fault_out(fault_out),
		.panel_loss_fault(panel_loss_fault), .reset_accept(rst_acc),
		.handheld_is_source(hh_src));
	pswl_panel_model pswl_panel_model_i (.core_clk(core_clk), .motor_running(motor_running),
		.stop_key_builtin(sk_b), .stop_key_handheld(sk_h), .mode_key_builtin(mk_b),
		.mode_key_handheld(mk_h), .handheld_panel_present(hh_on),
		.forward_start_input(fwd), .reverse_start_input(rev));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= pswl_pkg::ADDR_CFG;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1;
		cmp(reg_rdata, exp);
	endtask
	task automatic ck(input logic [9:0] n, input logic [1:0] k, input logic aw, input logic g);
		@(posedge core_clk);
		chk_valid <= 1'h1;
		chk_num <= n;
		chk_kind <= k;
		chk_aw <= aw;
		@(posedge core_clk);
		chk_valid <= 1'h0;
		#1;
		cmp(chk_done, 1'h1);
		cmp(chk_grant, g);
	endtask
	task automatic ckw(input logic [9:0] n, input logic aw, input logic g);
		ck(n, pswl_pkg::KIND_WRITE, aw, g);
	endtask
	task automatic st(input logic [1:0] m, input logic run);
		@(posedge core_clk);
		op_mode <= m;
		motor_running <= run;
	endtask
	task automatic comm(input logic acc);
		@(posedge core_clk);
		comm_reset <= 1'h1;
		@(posedge core_clk);
		comm_reset <= 1'h0;
		#1;
		cmp(rst_acc, acc);
		cyc(2);
	endtask
	task automatic lvl(input logic j, input logic r, input logic t);
		@(posedge core_clk);
		jog <= j;
		rs485 <= r;
		drive_tripped <= t;
	endtask
	task automatic stop_chk(input int k, input logic ps, input logic dc);
		pswl_panel_model_i.press(k);
		cyc(2);
		cmp(panel_stop_state, ps);
		cmp(decel_stop_cmd, dc);
	endtask
	initial begin
		#250000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'h1;
		rd(pswl_pkg::ADDR_CFG, 32'h0000_600e);
		rd(4'h8, 32'h0000_0000);
		wr(32'h0000_6010);
		cyc(60);
		cmp(panel_loss_fault, 1'h0);
		st(pswl_pkg::MODE_PANEL, 1'h0);
		ckw(10'h064, 1'h0, 1'h1);
		ck(10'h064, pswl_pkg::KIND_CLEAR, 1'h0, 1'h1);
		st(pswl_pkg::MODE_TERMINAL, 1'h0);
		ckw(10'h064, 1'h0, 1'h0);
		ckw(10'h048, 1'h0, 1'h0);
		st(pswl_pkg::MODE_PANEL, 1'h1);
		ckw(10'h064, 1'h0, 1'h0);
		ckw(10'h064, 1'h1, 1'h1);
		ckw(10'h048, 1'h0, 1'h1);
		ckw(10'h0f0, 1'h0, 1'h1);
		st(pswl_pkg::MODE_TERMINAL, 1'h1);
		ckw(10'h0f0, 1'h0, 1'h0);
		wr(32'h0000_6110);
		foreach (exc[i]) ckw(exc[i], 1'h0, 1'h1);
		ckw(10'h064, 1'h0, 1'h0);
		ck(10'h064, pswl_pkg::KIND_CLEAR, 1'h0, 1'h0);
		ck(10'h064, pswl_pkg::KIND_ALL_CLEAR, 1'h0, 1'h0);
		ck(10'h064, pswl_pkg::KIND_READ, 1'h0, 1'h1);
		wr(32'h0000_6210);
		ckw(10'h064, 1'h0, 1'h1);
		foreach (lck[i]) ckw(lck[i], 1'h0, 1'h0);
		ck(10'h064, pswl_pkg::KIND_CLEAR, 1'h0, 1'h0);
		st(pswl_pkg::MODE_TERMINAL, 1'h0);
		ckw(10'h050, 1'h0, 1'h1);
		wr(32'h0000_2210);
		ckw(10'h04d, 1'h0, 1'h0);
		wr(32'h0000_2010);
		rd(pswl_pkg::ADDR_CFG, 32'h0000_2210);
		wr(32'h0000_6210);
		wr(32'h0000_700e);
		$display("test write lock done");
		st(pswl_pkg::MODE_TERMINAL, 1'h1);
		pswl_panel_model_i.start(1'h1, 1'h1);
		cyc(6);
		stop_chk(0, 1'h1, 1'h1);
		cmp(stop_coast_sel, 1'h0);
		cmp(fault_out, 1'h0);
		cmp(run_permit, 1'h0);
		rd(pswl_pkg::ADDR_STATUS, 32'h0000_0001);
		stop_chk(3, 1'h1, 1'h1);
		st(pswl_pkg::MODE_TERMINAL, 1'h0);
		pswl_panel_model_i.stop_reset(0);
		cyc(2);
		cmp(panel_stop_state, 1'h0);
		cmp(run_permit, 1'h1);
		st(pswl_pkg::MODE_NETWORK, 1'h1);
		stop_chk(0, 1'h1, 1'h1);
		@(posedge core_clk);
		clear_input <= 1'h1;
		cyc(8);
		cmp(panel_stop_state, 1'h0);
		clear_input <= 1'h0;
		$display("test panel stop done");
		pswl_panel_model_i.attach(1'h1);
		cyc(6);
		cmp(hh_src, 1'h1);
		st(pswl_pkg::MODE_PANEL, 1'h1);
		stop_chk(0, 1'h1, 1'h1);
		comm(1'h1);
		cmp(panel_stop_state, 1'h0);
		stop_chk(1, 1'h0, 1'h1);
		st(pswl_pkg::MODE_PANEL, 1'h0);
		st(pswl_pkg::MODE_PANEL, 1'h1);
		lvl(1'h1, 1'h0, 1'h0);
		pswl_panel_model_i.attach(1'h0);
		cyc(8);
		cmp(decel_stop_cmd, 1'h1);
		lvl(1'h0, 1'h1, 1'h0);
		stop_chk(0, 1'h1, 1'h1);
		comm(1'h1);
		lvl(1'h0, 1'h0, 1'h0);
		$display("test panel mode done");
		st(pswl_pkg::MODE_PANEL, 1'h0);
		wr(32'h0000_6000);
		st(pswl_pkg::MODE_TERMINAL, 1'h1);
		stop_chk(0, 1'h0, 1'h0);
		st(pswl_pkg::MODE_PANEL, 1'h1);
		stop_chk(0, 1'h0, 1'h1);
		wr(32'h0000_600f);
		st(pswl_pkg::MODE_TERMINAL, 1'h1);
		stop_chk(0, 1'h1, 1'h1);
		comm(1'h0);
		cmp(panel_stop_state, 1'h1);
		lvl(1'h0, 1'h0, 1'h1);
		comm(1'h1);
		cmp(panel_stop_state, 1'h0);
		lvl(1'h0, 1'h0, 1'h0);
		$display("test low group done");
		wr(32'h0000_6010);
		pswl_panel_model_i.attach(1'h1);
		cyc(6);
		lvl(1'h0, 1'h1, 1'h0);
		pswl_panel_model_i.attach(1'h0);
		cyc(40);
		cmp(panel_loss_fault, 1'h0);
		lvl(1'h0, 1'h0, 1'h0);
		cyc(40);
		cmp(panel_loss_fault, 1'h1);
		cmp(fault_out, 1'h1);
		rd(pswl_pkg::ADDR_STATUS, 32'h0000_0082);
		$display("test panel loss done");
		end_sim();
	end
endmodule
